// *** design/eecpr_defines.svh ***
// Purpose: constants of the eeprom clock, irq and protection registers
// Assumes: byte-wide register port, registers at their printed offsets
// Notes:   offsets, fields, reset values, array geometry and timing counts only
//
// Contract
// - divider_loaded (bit 7) reads 0 until first divider write, then 1.
// - divider bits all readable; bits 6-0 write once; bit 7 not writable.
// - prescale_by_eight set divides oscillator clock by 8 before divider.
// - combined prescaler and divider reach division ratios up to 512.
// - both factory test registers read zero and ignore writes.
// - config bits 7 and 6 read/write; bits 5-0 read zero, not writable.
// - buffer-empty enable set requests irq while buffer empty flag is set.
// - complete enable set requests irq while all-done flag is set.
// - protection register loads from array byte 0x07FD on first edge after reset.
// - user persistent flags 6 to 4 readable, writes ignored.
// - global open and range disable only writable towards 0.
// - size bits writable while range disable is 1, frozen after.
// - global open 0 protects whole array; 1 enables unprotected sectors.
// - range disable 0 enables protected upper sector, 1 removes it.
// - size code 000 protects 64 bytes to 0x07FF, up to 512 at 0x0600.
// - program or erase into protected area refused, violation flagged.
// - mass erase only with global open and range disable both 1.
`ifndef EECPR_DEFINES_SVH
`define EECPR_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define EECPR_OFS_TIMEBASE_DIVIDER   4'h0
`define EECPR_OFS_FACTORY_TEST_ONE   4'h1
`define EECPR_OFS_FACTORY_TEST_TWO   4'h2
`define EECPR_OFS_INTERRUPT_CONFIG   4'h3
`define EECPR_OFS_SECTOR_PROTECTION  4'h4

// ****************************************************************
// field positions
// ****************************************************************
`define EECPR_BIT_DIVIDER_LOADED     7
`define EECPR_BIT_PRESCALE_BY_EIGHT  6
`define EECPR_BIT_BUF_EMPTY_IRQ_EN   7
`define EECPR_BIT_COMPLETE_IRQ_EN    6
`define EECPR_BIT_GLOBAL_OPEN        7
`define EECPR_BIT_RANGE_DISABLE      3

// ****************************************************************
// reset values and array geometry
// ****************************************************************
`define EECPR_RST_TIMEBASE_DIVIDER   8'h00
`define EECPR_RST_INTERRUPT_CONFIG   2'h0
`define EECPR_RST_SECTOR_PROTECTION  8'h00
`define EECPR_PROT_BYTE_ADDR         11'h7fd
`define EECPR_ARRAY_TOP_ADDR         11'h7ff
`define EECPR_SECTOR_FIRST_START     11'h7c0
`define EECPR_PRESCALE_LAST          3'h7
`define EECPR_READ_ZERO              8'h00

`endif

// *** design/eecpr_pkg.sv ***
// Purpose: types of the eeprom clock, irq and protection registers
// Assumes: constants live in eecpr_defines.svh
// Notes:   all state of the top is one packed struct
package eecpr_pkg;

   // ****************************************************************
   // protection load states
   // ****************************************************************
   typedef enum logic [1:0] {
      EECPR_ST_LOAD = 2'b01,
      EECPR_ST_RUN  = 2'b10
   } eecpr_state_t;

   typedef struct packed {
      logic       divider_loaded;
      logic       prescale_by_eight;
      logic [5:0] divide_value;
   } eecpr_divider_t;

   typedef struct packed {
      logic       global_open;
      logic [2:0] user_persistent_flags;
      logic       range_disable;
      logic [2:0] protect_size_sel;
   } eecpr_protect_t;

   typedef struct packed {
      eecpr_state_t   state;
      eecpr_divider_t divider;
      logic           buffer_empty_irq_enable;
      logic           complete_irq_enable;
      eecpr_protect_t protect;
      logic [2:0]     pre_cnt;
      logic [5:0]     div_cnt;
      logic           tick;
      logic [7:0]     rdata;
      logic           buf_irq;
      logic           done_irq;
      logic           grant;
      logic           violation;
   } eecpr_state_reg_t;

endpackage : eecpr_pkg

// *** design/eecpr_top.sv ***
// Purpose: clock divider, irq enables and sector protection registers
// Assumes: oscillator clock is mclk_i; inputs synchronous to mclk_i
// Notes:   read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "eecpr_defines.svh"

module eecpr_top (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic [7:0]  prot_byte_i,
   input  wire logic        buffer_empty_flag_i,
   input  wire logic        all_done_flag_i,
   input  wire logic        pe_req_i,
   input  wire logic        pe_mass_i,
   input  wire logic [10:0] pe_addr_i,
   output logic             pe_grant_o,
   output logic             protect_violation_o,
   output logic             buffer_empty_irq_o,
   output logic             complete_irq_o,
   output logic             timebase_tick_o
);

   eecpr_pkg::eecpr_state_reg_t s_reg;
   eecpr_pkg::eecpr_state_reg_t s_next;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // first protected address of the upper sector
   function automatic logic [10:0] sector_start(input logic [2:0] sel);
      sector_start = `EECPR_SECTOR_FIRST_START - {2'b00, sel, 6'h00};
   endfunction : sector_start

   function automatic logic is_protected(input eecpr_pkg::eecpr_protect_t p,
                                         input logic [10:0] addr);
      if (!p.global_open)
         is_protected = 1'b1;
      else if (p.range_disable)
         is_protected = 1'b0;
      else
         is_protected = (addr >= sector_start(p.protect_size_sel));
   endfunction : is_protected

   logic wr_div;
   logic wr_cfg;
   logic wr_prot;
   logic pre_pulse;
   logic refuse;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      s_next  = s_reg;
      wr_div  = reg_wr_i && (reg_addr_i == `EECPR_OFS_TIMEBASE_DIVIDER);
      wr_cfg  = reg_wr_i && (reg_addr_i == `EECPR_OFS_INTERRUPT_CONFIG);
      wr_prot = reg_wr_i && (reg_addr_i == `EECPR_OFS_SECTOR_PROTECTION);

      // protection byte is captured on the first edge after release,
      // never in the reset branch, so the flop only sees constants there
      case (s_reg.state)
         eecpr_pkg::EECPR_ST_LOAD:
         begin
            s_next.protect = prot_byte_i;
            s_next.state   = eecpr_pkg::EECPR_ST_RUN;
         end
         eecpr_pkg::EECPR_ST_RUN:
         begin
            if (wr_prot)
            begin
               // locks only move towards protected, reset alone reopens
               s_next.protect.global_open = s_reg.protect.global_open &
                  reg_wdata_i[`EECPR_BIT_GLOBAL_OPEN];
               s_next.protect.range_disable = s_reg.protect.range_disable &
                  reg_wdata_i[`EECPR_BIT_RANGE_DISABLE];
               if (s_reg.protect.range_disable)
                  s_next.protect.protect_size_sel = reg_wdata_i[2:0];
               // user_persistent_flags kept as loaded
            end
         end
         default:
         begin
            s_next.state = eecpr_pkg::EECPR_ST_LOAD;
         end
      endcase

      // write once, divider_loaded itself not writable
      if (wr_div && !s_reg.divider.divider_loaded)
      begin
         s_next.divider.prescale_by_eight =
            reg_wdata_i[`EECPR_BIT_PRESCALE_BY_EIGHT];
         s_next.divider.divide_value = reg_wdata_i[5:0];
         s_next.divider.divider_loaded = 1'b1;
      end

      if (wr_cfg)
      begin
         s_next.buffer_empty_irq_enable =
            reg_wdata_i[`EECPR_BIT_BUF_EMPTY_IRQ_EN];
         s_next.complete_irq_enable =
            reg_wdata_i[`EECPR_BIT_COMPLETE_IRQ_EN];
      end
      // factory test offsets take no write

      // timebase: optional /8 then /(divide_value+1); idle until loaded
      pre_pulse = !s_reg.divider.prescale_by_eight ||
                  (s_reg.pre_cnt == `EECPR_PRESCALE_LAST);
      s_next.tick = 1'b0;
      if (s_reg.divider.divider_loaded)
      begin
         s_next.pre_cnt = pre_pulse ? 3'h0 : s_reg.pre_cnt + 3'h1;
         if (pre_pulse)
         begin
            if (s_reg.div_cnt == s_reg.divider.divide_value)
            begin
               s_next.div_cnt = 6'h00;
               s_next.tick    = 1'b1;
            end
            else
            begin
               s_next.div_cnt = s_reg.div_cnt + 6'h01;
            end
         end
      end
      else
      begin
         s_next.pre_cnt = 3'h0;
         s_next.div_cnt = 6'h00;
      end

      // read port: data only in the cycle after the strobe
      s_next.rdata = `EECPR_READ_ZERO;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `EECPR_OFS_TIMEBASE_DIVIDER:
               s_next.rdata = s_reg.divider;
            `EECPR_OFS_INTERRUPT_CONFIG:
               s_next.rdata = {s_reg.buffer_empty_irq_enable,
                               s_reg.complete_irq_enable, 6'h00};
            `EECPR_OFS_SECTOR_PROTECTION:
               s_next.rdata = s_reg.protect;
            default:
               s_next.rdata = `EECPR_READ_ZERO;
         endcase
      end

      // level requests follow the flags while enabled
      s_next.buf_irq  = s_reg.buffer_empty_irq_enable &
                        buffer_empty_flag_i;
      s_next.done_irq = s_reg.complete_irq_enable & all_done_flag_i;

      // requests during the load cycle are judged fully protected
      if (pe_mass_i)
         refuse = !(s_reg.protect.global_open &&
                    s_reg.protect.range_disable);
      else
         refuse = is_protected(s_reg.protect, pe_addr_i);
      if (s_reg.state != eecpr_pkg::EECPR_ST_RUN)
         refuse = 1'b1;
      s_next.grant     = pe_req_i && !refuse;
      s_next.violation = pe_req_i && refuse;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_reg <= '{state:                   eecpr_pkg::EECPR_ST_LOAD,
                    divider:                 `EECPR_RST_TIMEBASE_DIVIDER,
                    buffer_empty_irq_enable: 1'b0,
                    complete_irq_enable:     1'b0,
                    protect:                 `EECPR_RST_SECTOR_PROTECTION,
                    pre_cnt:                 3'h0,
                    div_cnt:                 6'h00,
                    tick:                    1'b0,
                    rdata:                   8'h00,
                    buf_irq:                 1'b0,
                    done_irq:                1'b0,
                    grant:                   1'b0,
                    violation:               1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_o         = s_reg.rdata;
   assign pe_grant_o          = s_reg.grant;
   assign protect_violation_o = s_reg.violation;
   assign buffer_empty_irq_o  = s_reg.buf_irq;
   assign complete_irq_o      = s_reg.done_irq;
   assign timebase_tick_o     = s_reg.tick;

endmodule : eecpr_top

`default_nettype wire

// *** tb/eecpr_monitor.sv ***
// Purpose: port checker of the eecpr register block
// Assumes: one clock, asynchronous active-low reset
// Notes:   protection and enables are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module eecpr_monitor (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic [7:0]  prot_byte_i,
   input wire logic        buffer_empty_flag_i,
   input wire logic        all_done_flag_i,
   input wire logic        pe_req_i,
   input wire logic        pe_mass_i,
   input wire logic [10:0] pe_addr_i,
   input wire logic        pe_grant_o,
   input wire logic        protect_violation_o,
   input wire logic        buffer_empty_irq_o,
   input wire logic        complete_irq_o,
   input wire logic        timebase_tick_o
);
   // ****
   // shadow state, lq marks the load edge as done
   // ****
   logic [7:0] pq;
   logic [1:0] cq;
   logic       lq;
   logic       dq;
   always_ff @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         pq <= 8'h00;
         cq <= 2'h0;
         lq <= 1'b0;
         dq <= 1'b0;
      end
      else
      begin
         lq <= 1'b1;
         if (!lq)
            pq <= prot_byte_i;
         else if (reg_wr_i && reg_addr_i == 4'h4)
            pq <= {pq[7] & reg_wdata_i[7], pq[6:4], pq[3] & reg_wdata_i[3],
                   pq[3] ? reg_wdata_i[2:0] : pq[2:0]};
         if (reg_wr_i && reg_addr_i == 4'h3)
            cq <= reg_wdata_i[7:6];
         if (reg_wr_i && reg_addr_i == 4'h0)
            dq <= 1'b1;
      end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // ****
   // assertions
   // ****
   a_rsvd_read_zero: assert property (
      $past(reg_rd_i && (reg_addr_i inside {4'h1, 4'h2} || reg_addr_i > 4'h4))
      |-> reg_rdata_o == 8'h00) else $error("reserved read not zero");
   a_cfg_read_back: assert property (
      $past(reg_rd_i && reg_addr_i == 4'h3)
      |-> reg_rdata_o == {$past(cq), 6'h00}) else $error("config read");
   a_buf_irq_gate: assert property (
      buffer_empty_irq_o == $past(cq[1] & buffer_empty_flag_i))
      else $error("buffer empty irq");
   a_done_irq_gate: assert property (
      complete_irq_o == $past(cq[0] & all_done_flag_i))
      else $error("complete irq");
   a_one_result: assert property (
      (pe_grant_o | protect_violation_o) == $past(pe_req_i)
      && !(pe_grant_o & protect_violation_o)) else $error("pe result");
   a_closed_refuse: assert property (
      $past(pe_req_i && !(lq && pq[7])) |-> protect_violation_o)
      else $error("closed array granted");
   a_mass_gate: assert property (
      $past(pe_req_i && pe_mass_i && lq) |-> pe_grant_o == $past(pq[7] & pq[3]))
      else $error("mass erase gate");
   a_range_gate: assert property (
      $past(pe_req_i && !pe_mass_i && lq && pq[7]) |-> protect_violation_o ==
      $past(!pq[3] && pe_addr_i >= 11'h7c0 - {2'h0, pq[2:0], 6'h00}))
      else $error("sector range");
   a_prot_read: assert property (
      $past(reg_rd_i && reg_addr_i == 4'h4 && lq)
      |-> reg_rdata_o == $past(pq)) else $error("protection read");
   a_div_loaded: assert property (
      $past(reg_rd_i && reg_addr_i == 4'h0)
      |-> reg_rdata_o[7] == $past(dq)) else $error("divider loaded bit");
   a_no_early_tick: assert property (
      !dq |-> !timebase_tick_o) else $error("tick before load");
   c_mass_grant: cover property (pe_grant_o && $past(pe_mass_i));
   c_violation: cover property (protect_violation_o);
   c_tick: cover property (timebase_tick_o);
endmodule : eecpr_monitor
bind eecpr_top eecpr_monitor u_mon (.*);
`default_nettype wire

// *** tb/eecpr_test.sv ***
// Purpose: self-checking bench of the eecpr register block
// Assumes: read data stand in the cycle after the strobe
// Notes:   each row writes a register then reads it back
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] %0t ns got %h want %h", $time, a, b); end end
module eecpr_test;
   logic        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, pe_req_i, pe_mass_i;
   logic        buffer_empty_flag_i, all_done_flag_i, pe_grant_o;
   logic        protect_violation_o, buffer_empty_irq_o, complete_irq_o;
   logic        timebase_tick_o;
   logic [3:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i, reg_rdata_o, prot_byte_i, q;
   logic [10:0] pe_addr_i;
   int          fails, tests_run, k;
   // addr, write data, read-back value
   logic [19:0] rows [11] = '{20'h488f8, 20'h1ff00, 20'h2ff00, 20'h5ff00,
      20'h3ffc0, 20'h34040, 20'h48dfd, 20'h482f2, 20'h48ff2, 20'h00585,
      20'h03f85};
   eecpr_top dut (.*);
   // ****
   // bus tasks
   // ****
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask : rd
   task automatic pe(input logic m, input logic [10:0] a, input logic g);
      @(posedge mclk_i);
      pe_req_i  <= 1'b1;
      pe_mass_i <= m;
      pe_addr_i <= a;
      @(posedge mclk_i);
      pe_req_i  <= 1'b0;
      #1;
      `CHK({pe_grant_o, protect_violation_o}, {g, !g})
   endtask : pe
   task automatic tick_gap(output int n);
      n = 0;
      while (timebase_tick_o !== 1'b1 && n < 600)
      begin
         @(posedge mclk_i);
         #1 n++;
      end
      n = 0;
      do
      begin
         @(posedge mclk_i);
         #1 n++;
      end
      while (timebase_tick_o !== 1'b1 && n < 600);
   endtask : tick_gap
   task automatic print_verdict;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // ****
   // clock, watchdog, sequence
   // ****
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   initial
   begin
      #20000;
      fails++;
      print_verdict();
   end
   initial
   begin
      {rst_n_i, reg_wr_i, reg_rd_i, pe_req_i, pe_mass_i} = 5'h00;
      {buffer_empty_flag_i, all_done_flag_i} = 2'h0;
      {reg_addr_i, reg_wdata_i, pe_addr_i} = 23'h000000;
      prot_byte_i = 8'hf8;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i][19:16], rows[i][15:8]);
         rd(rows[i][19:16], q);
         `CHK(q, rows[i][7:0])
      end
      $display("register table test done");
      tick_gap(k);
      `CHK(k, 6)
      $display("timebase test done");
      @(posedge mclk_i);
      buffer_empty_flag_i <= 1'b1;
      all_done_flag_i     <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
      `CHK({buffer_empty_irq_o, complete_irq_o}, 2'b01)
      wr(4'h3, 8'h80);
      repeat (2) @(posedge mclk_i);
      #1;
      `CHK({buffer_empty_irq_o, complete_irq_o}, 2'b10)
      $display("irq test done");
      pe(1'b0, 11'h73f, 1'b1);
      pe(1'b0, 11'h740, 1'b0);
      pe(1'b1, 11'h000, 1'b0);
      wr(4'h4, 8'h00);
      pe(1'b0, 11'h000, 1'b0);
      $display("protection test done");
      @(posedge mclk_i);
      prot_byte_i <= 8'h88; // byte reprogrammed while closed, loads after reset
      rst_n_i     <= 1'b0;
      repeat (5) @(posedge mclk_i);
      rst_n_i     <= 1'b1;
      rd(4'h0, q);
      `CHK(q, 8'h00)
      rd(4'h4, q);
      `CHK(q, 8'h88)
      pe(1'b1, 11'h000, 1'b1);
      pe(1'b0, 11'h7ff, 1'b1);
      wr(4'h0, 8'h7f); // slowest rate this clock reaches
      rd(4'h0, q);
      `CHK(q, 8'hff)
      tick_gap(k);
      `CHK(k, 512)
      $display("second reset test done");
      print_verdict();
   end
endmodule : eecpr_test
`default_nettype wire
